/* File: auto_reload_capture_timer.sv */
// Auto-reload / capture timer reached through special function registers.
// Assumes one register write per cycle on the port; reads are registered.
`timescale 1ns/1ps
`default_nettype none

module auto_reload_capture_timer (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic ext_osc,
    input wire logic timer_interrupt_enable,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    output logic irq
);

    logic [7:0] timer_control_r;
    logic [7:0] clock_configuration_register_r;
    logic [7:0] reload_low_byte_r;
    logic [7:0] reload_high_byte_r;
    logic [7:0] counter_low_byte_r;
    logic [7:0] counter_high_byte_r;

    wire tick_div12;
    wire tick_ext8;

    // Shared prescaler and external clock divider
    timebase_ticks #(
        .PRESCALE(timer_pkg::SYS_PRESCALE),
        .EXT_DIV(timer_pkg::EXT_DIVIDE)
    ) u_ticks (
        .clock(clock),
        .sys_rst(sys_rst),
        .ext_osc(ext_osc),
        .tick_div12(tick_div12),
        .tick_ext8(tick_ext8)
    );

    // Byte clock choice: system clock, /12, or external /8
    function automatic logic pick_tick(input logic sel_sys,
                                       input logic xclk,
                                       input logic t12,
                                       input logic t8);
        pick_tick = sel_sys | (xclk ? t8 : t12);
    endfunction

    // Control fields
    wire high_flag = timer_control_r[timer_pkg::CTL_HIGH_FLAG];
    wire low_flag = timer_control_r[timer_pkg::CTL_LOW_FLAG];
    wire low_interrupt_enable = timer_control_r[timer_pkg::CTL_LOW_IE];
    wire capture_enable = timer_control_r[timer_pkg::CTL_CAPTURE];
    wire split_mode_bit = timer_control_r[timer_pkg::CTL_SPLIT];
    wire run_bit = timer_control_r[timer_pkg::CTL_RUN];
    wire external_clock_select = timer_control_r[timer_pkg::CTL_XCLK];
    wire high_byte_clock_select =
        clock_configuration_register_r[timer_pkg::CKC_HIGH_SEL];
    wire low_byte_clock_select =
        clock_configuration_register_r[timer_pkg::CKC_LOW_SEL];

    // Register write decode
    wire wr_control = sfr_wr & (sfr_addr == timer_pkg::ADDR_CONTROL);
    wire wr_clock_cfg = sfr_wr & (sfr_addr == timer_pkg::ADDR_CLOCK_CONFIG);
    wire wr_reload_low = sfr_wr & (sfr_addr == timer_pkg::ADDR_RELOAD_LOW);
    wire wr_reload_high = sfr_wr & (sfr_addr == timer_pkg::ADDR_RELOAD_HIGH);
    wire wr_count_low = sfr_wr & (sfr_addr == timer_pkg::ADDR_COUNT_LOW);
    wire wr_count_high = sfr_wr & (sfr_addr == timer_pkg::ADDR_COUNT_HIGH);

    // Tick selection; in capture mode the low byte never counts on the measured clock
    wire normal_low_tick = pick_tick(low_byte_clock_select,
                                     external_clock_select,
                                     tick_div12, tick_ext8);
    wire capture_low_tick = pick_tick(low_byte_clock_select, 1'b0,
                                      tick_div12, tick_ext8);
    wire low_tick = capture_enable ? capture_low_tick : normal_low_tick;
    // High select only matters when the bytes run apart
    wire high_tick = pick_tick(high_byte_clock_select,
                               external_clock_select,
                               tick_div12, tick_ext8);

    // Increment enables per mode
    wire low_inc = split_mode_bit ? low_tick : (run_bit & low_tick);
    wire low_roll = low_inc & (counter_low_byte_r == timer_pkg::BYTE_MAX);
    wire high_inc = split_mode_bit ? (run_bit & high_tick) : low_roll;
    wire high_roll = high_inc & (counter_high_byte_r == timer_pkg::BYTE_MAX);

    // Reload decisions; a 16-bit capture run wraps freely so deltas stay valid
    wire full_reload = ~split_mode_bit & high_roll & ~capture_enable;
    wire low_reload = split_mode_bit ? low_roll : full_reload;
    wire high_reload = split_mode_bit ? high_roll : full_reload;
    wire capture_event = capture_enable & tick_ext8;

    // Next counter values; a software write beats the count
    wire [7:0] low_count_nxt =
        wr_count_low ? sfr_wdata :
        low_reload ? reload_low_byte_r :
        low_inc ? counter_low_byte_r + timer_pkg::BYTE_ONE :
        counter_low_byte_r;
    wire [7:0] high_count_nxt =
        wr_count_high ? sfr_wdata :
        high_reload ? reload_high_byte_r :
        high_inc ? counter_high_byte_r + timer_pkg::BYTE_ONE :
        counter_high_byte_r;

    // Capture overrides a same-cycle software write of the reload pair
    wire [7:0] reload_low_nxt =
        capture_event ? counter_low_byte_r :
        wr_reload_low ? sfr_wdata : reload_low_byte_r;
    wire [7:0] reload_high_nxt =
        capture_event ? counter_high_byte_r :
        wr_reload_high ? sfr_wdata : reload_high_byte_r;

    // Flag set events; hardware has no clear path
    wire high_set = high_roll | capture_event;
    wire low_set = low_roll;
    wire [7:0] control_written =
        wr_control ? (sfr_wdata & timer_pkg::CTL_WRITE_MASK) :
        timer_control_r;
    wire [7:0] flag_set_bits = {high_set, low_set, 6'h00};
    // Set wins over a software clear in the same cycle
    wire [7:0] control_nxt = control_written | flag_set_bits;

    wire [7:0] clock_cfg_nxt =
        wr_clock_cfg ? (sfr_wdata & timer_pkg::CKC_OWN_MASK) :
        clock_configuration_register_r;

    // Interrupt condition: high flag always, low flag only when enabled
    wire irq_nxt = timer_interrupt_enable &
        (high_flag | (low_flag & low_interrupt_enable));

    // Read mux; unmapped addresses return zero
    wire [7:0] read_mux =
        (sfr_addr == timer_pkg::ADDR_CONTROL) ? timer_control_r :
        (sfr_addr == timer_pkg::ADDR_CLOCK_CONFIG) ?
            clock_configuration_register_r :
        (sfr_addr == timer_pkg::ADDR_RELOAD_LOW) ? reload_low_byte_r :
        (sfr_addr == timer_pkg::ADDR_RELOAD_HIGH) ? reload_high_byte_r :
        (sfr_addr == timer_pkg::ADDR_COUNT_LOW) ? counter_low_byte_r :
        (sfr_addr == timer_pkg::ADDR_COUNT_HIGH) ? counter_high_byte_r :
        timer_pkg::RESET_BYTE;

    // Counter bytes
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            counter_low_byte_r <= timer_pkg::RESET_BYTE;
            counter_high_byte_r <= timer_pkg::RESET_BYTE;
        end else begin
            counter_low_byte_r <= low_count_nxt;
            counter_high_byte_r <= high_count_nxt;
        end
    end

    // Reload pair, shared with capture results
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            reload_low_byte_r <= timer_pkg::RESET_BYTE;
            reload_high_byte_r <= timer_pkg::RESET_BYTE;
        end else begin
            reload_low_byte_r <= reload_low_nxt;
            reload_high_byte_r <= reload_high_nxt;
        end
    end

    // Control and clock configuration
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            timer_control_r <= timer_pkg::RESET_BYTE;
            clock_configuration_register_r <= timer_pkg::RESET_BYTE;
        end else begin
            timer_control_r <= control_nxt;
            clock_configuration_register_r <= clock_cfg_nxt;
        end
    end

    // Registered outputs: read data and level interrupt request
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            sfr_rdata <= timer_pkg::RESET_BYTE;
            irq <= 1'b0;
        end else begin
            sfr_rdata <= read_mux;
            irq <= irq_nxt;
        end
    end

endmodule

`default_nettype wire

/* File: auto_reload_capture_timer_test.sv */
// Self-checking bench for the auto-reload / capture timer.
// Assumes registered reads and an oscillator slower than clock / 2.
`timescale 1ns/1ps
`default_nettype none
module auto_reload_capture_timer_test;
    logic clock, sys_rst, ext_osc, tie, wr, irq;
    logic [7:0] addr, wdata, rdata, v;
    logic [15:0] c1, d;
    int errors = 0;
    int n_checks = 0;
    auto_reload_capture_timer dut (.clock(clock), .sys_rst(sys_rst),
        .ext_osc(ext_osc), .timer_interrupt_enable(tie),
        .sfr_addr(addr), .sfr_wr(wr), .sfr_wdata(wdata),
        .sfr_rdata(rdata), .irq(irq));
    // 125 MHz clock
    initial begin
        clock = 0;
        forever #4 clock = ~clock;
    end
    // Oscillator of six clocks, changed on falling edges like every input except tie in t_split
    initial begin
        ext_osc = 0;
        forever begin
            repeat (3) @(negedge clock);
            ext_osc = ~ext_osc;
        end
    end
    task automatic summarize();
        if (errors == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wreg(input logic [7:0] a, input logic [7:0] dt);
        @(negedge clock);
        addr = a;
        wdata = dt;
        wr = 1;
        @(negedge clock);
        wr = 0;
    endtask
    // Read data lands one edge after the address
    task automatic rreg(input logic [7:0] a);
        @(negedge clock);
        addr = a;
        @(posedge clock);
        #1 v = rdata;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        rreg(a);
        check(v, e);
    endtask
    // Bounded poll of one control bit
    task automatic wflag(input int b);
        for (int i = 0; i < 3000; i++) begin
            rreg(8'hC8);
            if (v[b] === 1'b1)
                return;
        end
        errors++;
        summarize();
    endtask
    task automatic t_regs();
        rchk(8'hC8, 8'h00);
        rchk(8'hCD, 8'h00);
        wreg(8'hC8, 8'h02);
        rchk(8'hC8, 8'h00);
        wreg(8'h8E, 8'hFF);
        rchk(8'h8E, 8'h30);
        wreg(8'hC9, 8'hFF);
        rchk(8'hC9, 8'h00);
        wreg(8'hCD, 8'h5A);
        rchk(8'hCD, 8'h5A);
        wreg(8'hC8, 8'h29);
        rchk(8'hC8, 8'h29);
        wreg(8'hC8, 8'h00);
    endtask
    task automatic t_wide();
        wreg(8'h8E, 8'h10);
        wreg(8'hCA, 8'h34);
        wreg(8'hCB, 8'h12);
        wreg(8'hCC, 8'hF0);
        wreg(8'hCD, 8'hFF);
        tie = 1;
        wreg(8'hC8, 8'h04);
        wflag(7);
        rchk(8'hCD, 8'h12);
        rchk(8'hC8, 8'hC4);
        check({7'h00, irq}, 8'h01);
        wreg(8'hC8, 8'h04);
        repeat (2) @(negedge clock);
        check({7'h00, irq}, 8'h00);
        wflag(6);
        check({7'h00, irq}, 8'h00);
        wreg(8'hC8, 8'h64);
        repeat (2) @(negedge clock);
        check({7'h00, irq}, 8'h01);
        tie = 0;
        repeat (2) @(negedge clock);
        check({7'h00, irq}, 8'h00);
        wreg(8'hC8, 8'h00);
    endtask
    task automatic t_split();
        wreg(8'h8E, 8'h30);
        wreg(8'hCA, 8'h80);
        wreg(8'hCB, 8'h70);
        wreg(8'hCD, 8'h50);
        wreg(8'hCC, 8'hF0);
        wreg(8'hC8, 8'h08);
        wflag(6);
        rchk(8'hCD, 8'h50);
        rreg(8'hCC);
        check(v & 8'h80, 8'h80);
        rchk(8'hC8, 8'h48);
        wreg(8'hCD, 8'hFE);
        tie = 1;
        wreg(8'hC8, 8'h0C);
        wflag(7);
        rreg(8'hCD);
        check(v & 8'hF0, 8'h70);
        check({7'h00, irq}, 8'h01);
        tie = 0;
        wreg(8'hC8, 8'h00);
    endtask
    // Count over a fixed span under one clock choice
    task automatic rate(input logic [7:0] ctl, input int n, input int lo);
        wreg(8'h8E, 8'h00);
        wreg(8'hCC, 8'h00);
        wreg(8'hC8, ctl);
        repeat (n) @(negedge clock);
        rreg(8'hCC);
        wreg(8'hC8, 8'h00);
        check({7'h00, v >= lo && v <= lo + 2}, 8'h01);
    endtask
    task automatic t_rates();
        rate(8'h04, 120, 9);
        rate(8'h05, 240, 4);
    endtask
    task automatic t_capture();
        wreg(8'h8E, 8'h10);
        wreg(8'hCD, 8'h00);
        wreg(8'hC8, 8'h14);
        wflag(7);
        rreg(8'hCA);
        c1[7:0] = v;
        rreg(8'hCB);
        c1[15:8] = v;
        wreg(8'hC8, 8'h14);
        wflag(7);
        rreg(8'hCA);
        d[7:0] = v;
        rreg(8'hCB);
        d[15:8] = v;
        d = d - c1;
        check(d[15:8], 8'h00);
        check(d[7:0], 8'h30);
        wreg(8'hC8, 8'h00);
    endtask
    // Reset for 20 cycles, then the scenarios
    initial begin
        tie = 0;
        wr = 0;
        addr = 8'h00;
        wdata = 8'h00;
        sys_rst = 1;
        repeat (20) @(negedge clock);
        sys_rst = 0;
        t_regs();
        t_wide();
        t_split();
        t_rates();
        t_capture();
        summarize();
    end
endmodule
`default_nettype wire

/* File: timebase_ticks.sv */
// Timebase for the timer: one-cycle ticks at system clock / 12 and at
// external oscillator / 8, both on the system clock.
// Assumes the external oscillator is slower than half the system clock.
`timescale 1ns/1ps
`default_nettype none

module timebase_ticks #(
    parameter int PRESCALE = timer_pkg::SYS_PRESCALE,
    parameter int EXT_DIV = timer_pkg::EXT_DIVIDE
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic ext_osc,
    output logic tick_div12,
    output logic tick_ext8
);

    localparam logic [3:0] PRE_LAST = 4'(PRESCALE - 1);
    localparam logic [2:0] EXT_LAST = 3'(EXT_DIV - 1);

    logic sync1_r;
    logic sync2_r;
    logic prev_r;
    logic [2:0] ext_cnt_r;
    logic [3:0] pre_cnt_r;
    wire ext_rise;
    wire pre_wrap;
    wire ext_wrap;

    // Two-stage synchroniser; only the second stage feeds logic
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            prev_r <= 1'b0;
        end else begin
            sync1_r <= ext_osc;
            sync2_r <= sync1_r;
            prev_r <= sync2_r;
        end
    end

    assign ext_rise = sync2_r & ~prev_r;
    assign pre_wrap = (pre_cnt_r == PRE_LAST);
    // Divided clock falls as the counter wraps back to zero
    assign ext_wrap = ext_rise & (ext_cnt_r == EXT_LAST);

    // Free-running dividers
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            pre_cnt_r <= 4'h0;
            ext_cnt_r <= 3'h0;
            tick_div12 <= 1'b0;
            tick_ext8 <= 1'b0;
        end else begin
            pre_cnt_r <= pre_wrap ? 4'h0 : pre_cnt_r + 4'h1;
            if (ext_rise)
                ext_cnt_r <= ext_cnt_r + 3'h1;
            tick_div12 <= pre_wrap;
            tick_ext8 <= ext_wrap;
        end
    end

endmodule

`default_nettype wire

/* File: timer_asserts.sv */
// Port checker for the timer: read data and interrupt level.
// Assumes one clock domain and registered read data.
`timescale 1ns/1ps
`default_nettype none
module timer_asserts (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic ext_osc,
    input wire logic timer_interrupt_enable,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic irq
);
    wire logic mapped;
    // Addresses that answer a read
    assign mapped = sfr_addr inside {8'hC8, 8'hCA, 8'hCB, 8'hCC, 8'hCD, 8'h8E};
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    sequence wr_rd(a);
        sfr_wr && sfr_addr == a ##1 !sfr_wr && sfr_addr == a;
    endsequence
    chk_reset_clears: assert property (
        $past(sys_rst) |-> sfr_rdata == 8'h00 && !irq)
        else $error("read data or irq not cleared by reset");
    chk_unused_bit1: assert property (
        $past(sfr_addr) == 8'hC8 |-> !sfr_rdata[1])
        else $error("control bit 1 reads one");
    chk_ckc_unused: assert property (
        $past(sfr_addr) == 8'h8E |-> (sfr_rdata & 8'hCF) == 8'h00)
        else $error("clock config unused bits read one");
    chk_unmapped_zero: assert property (
        !$past(mapped) |-> sfr_rdata == 8'h00)
        else $error("unmapped address reads nonzero");
    chk_irq_gated: assert property (
        !$past(timer_interrupt_enable) |-> !irq)
        else $error("irq without timer interrupt enable");
    // Request lags the flags by one edge, so a write one edge back counts
    chk_irq_holds: assert property (
        irq && timer_interrupt_enable && !sfr_wr && !$past(sfr_wr)
        |=> irq)
        else $error("irq dropped without software action");
    chk_ctl_readback: assert property (
        wr_rd(8'hC8) |=> (sfr_rdata & 8'h3D) == ($past(sfr_wdata, 2) & 8'h3D))
        else $error("control readback differs");
    chk_ckc_readback: assert property (
        wr_rd(8'h8E) |=> sfr_rdata == ($past(sfr_wdata, 2) & 8'h30))
        else $error("clock config readback differs");
    // Main scenarios reached
    cover property ($rose(irq));
    cover property ($past(sfr_addr) == 8'hC8 && sfr_rdata[7]);
    cover property (wr_rd(8'hCD));
endmodule
bind auto_reload_capture_timer timer_asserts u_chk (.clock(clock),
    .sys_rst(sys_rst), .ext_osc(ext_osc),
    .timer_interrupt_enable(timer_interrupt_enable),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .irq(irq));
`default_nettype wire

/* File: timer_pkg.sv */
// Constants for the auto-reload / capture timer: register addresses,
// bit positions, reset values and prescale counts.
// Assumes the special function register port is 8 bits wide.
//
// Contract
// - Split bit clear: one 16-bit counter; at wrap, reload and set high flag. With capture set it wraps to zero instead of reloading.
// - 16-bit mode: interrupt on every full overflow while enabled.
// - 16-bit mode: with low enable too, request interrupt on low-byte wrap.
// - Split bit set: two 8-bit timers, each reloading from its own byte.
// - Split mode: run bit gates high byte only; low byte always counts.
// - Byte clock: system clock if its select is 1, else /12 or ext/8.
// - External clock /8 is synchronised before it advances the timer.
// - High flag set on high-byte wrap; low flag set on low-byte wrap.
// - Split mode: interrupt on high wrap; also low wrap when low enable set.
// - Hardware never clears overflow flags; software clears and checks both.
// - Low flag sets on every low-byte wrap in either mode.
// - Capture bit 4: each capture copies count to reload, sets high flag.
// - Capture event on each falling edge of external clock divided by eight.
// - Capture mode: low byte counts on system clock or system clock divided by twelve.
// - Control bits: 7 high flag, 6 low flag, 5,4,3,2, 0 clock select.
// - Control bit 1 unused: reads zero, writes ignored.
// - Clock config bit 5 high-byte select, bit 4 low; bit 5 split only.
// - High reload at 0xCB, counter bytes 0xCC/0xCD, read/write, reset zero.

`default_nettype none

package timer_pkg;

    // Special function register addresses
    localparam logic [7:0] ADDR_CONTROL = 8'hC8;
    localparam logic [7:0] ADDR_RELOAD_LOW = 8'hCA;
    localparam logic [7:0] ADDR_RELOAD_HIGH = 8'hCB;
    localparam logic [7:0] ADDR_COUNT_LOW = 8'hCC;
    localparam logic [7:0] ADDR_COUNT_HIGH = 8'hCD;
    localparam logic [7:0] ADDR_CLOCK_CONFIG = 8'h8E;

    // Control register fields
    localparam int CTL_HIGH_FLAG = 7;
    localparam int CTL_LOW_FLAG = 6;
    localparam int CTL_LOW_IE = 5;
    localparam int CTL_CAPTURE = 4;
    localparam int CTL_SPLIT = 3;
    localparam int CTL_RUN = 2;
    localparam int CTL_XCLK = 0;
    localparam logic [7:0] CTL_WRITE_MASK = 8'hFD;

    // Clock configuration fields owned by this timer
    localparam int CKC_HIGH_SEL = 5;
    localparam int CKC_LOW_SEL = 4;
    localparam logic [7:0] CKC_OWN_MASK = 8'h30;

    // Reset and wrap values
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [7:0] BYTE_MAX = 8'hFF;
    localparam logic [7:0] BYTE_ONE = 8'h01;

    // Timebase division figures
    localparam int SYS_PRESCALE = 12;
    localparam int EXT_DIVIDE = 8;

endpackage

`default_nettype wire
